// File: src/otb_trigger_gate.sv
// Purpose: Start, stop and count cycles of a free-running waveform oscillator
// Assumes: Oscillator square and trigger pins are asynchronous to i_ref_clk
// Notes:   Oscillator rising edges and trigger edges are sampled, not used as clocks
//
// Contract
// - Four trigger modes: continuous, triggered single cycle, gated, counted burst.
// - Trigger rising edge becomes a pulse resetting run-hold, and burst-end in burst.
// - Continuous mode holds run-hold reset; clamp never applied.
// - Triggered mode: run-hold data is one; oscillator rising edge sets clamp.
// - Triggered mode: trigger releases clamp; one oscillator cycle per trigger.
// - Gated mode: high level runs; low level stops after current cycle.
// - Burst mode: data not forced; idle run-hold stays one, oscillator clamped.
// - Burst trigger resets run-hold and burst-end; edges re-set run-hold only once burst-end is set.
// - Count edges in 12 bits; edge after FFF sets burst-end, then clamp.
// - Burst mode sync output is active for the whole burst.
`timescale 1ns/10ps
`include "otb_cfg.svh"

module otb_trigger_gate
  import otb_pkg::*;
(
  // Clock and reset
  input  wire logic                  i_ref_clk,
  input  wire logic                  i_rst_b,
  // Configuration
  input  wire logic [`OTB_MODE_W-1:0] i_trig_mode,
  input  wire logic [`OTB_CNT_W-1:0]  i_burst_cycles,
  // Oscillator and trigger pins
  input  wire logic                  i_osc_square,
  input  wire logic                  i_trig_in,
  // Outputs
  output logic                       o_clamp,
  output logic                       o_sync,
  output logic                       o_burst_end
);

  otb_mode_t mode;
  logic rst_meta_reg, rst_b_reg;
  logic rst_b;
  logic [2:0] osc_pipe_reg, osc_pipe_next;
  logic [2:0] trg_pipe_reg, trg_pipe_next;
  logic osc_rise, trig_pulse, gate_lvl, osc_lvl;
  logic run_hold_reg, run_hold_next;
  logic burst_end_reg, burst_end_next;
  logic sync_reg, sync_next;
  logic cnt_load, cnt_step, cnt_at_max;
  logic [`OTB_CNT_W-1:0] cnt_val, preload;
  logic [`OTB_CNT_W-1:0] cycles_eff;

  // Reset release through two flops
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rst_meta_reg <= 1'b0;
      rst_b_reg    <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_b_reg    <= rst_meta_reg;
    end
  end
  assign rst_b = rst_b_reg;

  // Pin synchronisers plus one edge stage
  always_comb begin
    osc_pipe_next = {osc_pipe_reg[1:0], i_osc_square};
    trg_pipe_next = {trg_pipe_reg[1:0], i_trig_in};
  end

  always_ff @(posedge i_ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      osc_pipe_reg <= 3'h0;
      trg_pipe_reg <= 3'h0;
    end else begin
      osc_pipe_reg <= osc_pipe_next;
      trg_pipe_reg <= trg_pipe_next;
    end
  end

  assign osc_lvl    = osc_pipe_reg[1];
  assign osc_rise   = osc_pipe_reg[1] & ~osc_pipe_reg[2];
  assign gate_lvl   = trg_pipe_reg[1];
  assign trig_pulse = trg_pipe_reg[1] & ~trg_pipe_reg[2];

  assign mode = otb_mode_t'(i_trig_mode);

  assign cycles_eff = (i_burst_cycles < `OTB_BURST_MIN) ? `OTB_BURST_MIN : i_burst_cycles;
  assign preload    = `OTB_CNT_MAX - cycles_eff + `OTB_PRELOAD_BIAS;

  assign cnt_load = (mode == OTB_MODE_BURST) && trig_pulse;
  assign cnt_step = (mode == OTB_MODE_BURST) && osc_rise && !run_hold_reg;

  otb_burst_counter u_burst_counter (
    .i_ref_clk  (i_ref_clk),
    .i_rst_b    (rst_b),
    .i_load     (cnt_load),
    .i_load_val (preload),
    .i_step     (cnt_step),
    .o_count    (cnt_val),
    .o_at_max   (cnt_at_max)
  );

  always_comb begin
    run_hold_next  = run_hold_reg;
    burst_end_next = burst_end_reg;
    sync_next      = sync_reg;
    case (mode)
      OTB_MODE_CONT: begin
        run_hold_next  = `OTB_HOLD_RUN;
        burst_end_next = 1'b0;
        sync_next      = osc_lvl;
      end
      OTB_MODE_TRIG: begin
        burst_end_next = 1'b0;
        sync_next      = gate_lvl;
        if (trig_pulse) begin
          run_hold_next = `OTB_HOLD_RUN;
        end else if (osc_rise) begin
          run_hold_next = `OTB_HOLD_CLAMP;
        end
      end
      OTB_MODE_GATED: begin
        burst_end_next = 1'b0;
        sync_next      = gate_lvl;
        // level reset, stop at cycle end
        if (gate_lvl) begin
          run_hold_next = `OTB_HOLD_RUN;
        end else if (osc_rise) begin
          run_hold_next = `OTB_HOLD_CLAMP;
        end
      end
      OTB_MODE_BURST: begin
        if (trig_pulse) begin
          run_hold_next  = `OTB_HOLD_RUN;
          burst_end_next = 1'b0;
        end else if (osc_rise) begin
          run_hold_next = burst_end_reg | run_hold_reg;
          if (cnt_at_max && !run_hold_reg) begin
            burst_end_next = 1'b1;
          end
        end
        sync_next = !run_hold_next;
      end
      default: begin
        run_hold_next = `OTB_HOLD_CLAMP;
      end
    endcase
  end

  always_ff @(posedge i_ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      run_hold_reg  <= `OTB_HOLD_CLAMP;
      burst_end_reg <= 1'b0;
      sync_reg      <= 1'b0;
    end else begin
      run_hold_reg  <= run_hold_next;
      burst_end_reg <= burst_end_next;
      sync_reg      <= sync_next;
    end
  end

  assign o_clamp     = run_hold_reg;
  assign o_sync      = sync_reg;
  assign o_burst_end = burst_end_reg;

  // Checks
  sequence s_burst_last;
    (mode == OTB_MODE_BURST) && osc_rise && cnt_at_max && !run_hold_reg && !trig_pulse;
  endsequence

  sequence s_burst_stop;
    burst_end_reg && (mode == OTB_MODE_BURST) && osc_rise && !trig_pulse;
  endsequence

  property p_cont_free;
    @(posedge i_ref_clk) disable iff (!rst_b)
    (mode == OTB_MODE_CONT) |=> !o_clamp;
  endproperty
  a_cont_free: assert property (p_cont_free) else $error("clamp in continuous mode");

  property p_trig_clamp;
    @(posedge i_ref_clk) disable iff (!rst_b)
    (mode == OTB_MODE_TRIG) && osc_rise && !trig_pulse |=> o_clamp;
  endproperty
  a_trig_clamp: assert property (p_trig_clamp) else $error("edge did not clamp");

  property p_trig_release;
    @(posedge i_ref_clk) disable iff (!rst_b)
    (mode == OTB_MODE_TRIG) && trig_pulse |=> !o_clamp;
  endproperty
  a_trig_release: assert property (p_trig_release) else $error("trigger did not release");

  property p_gate_run;
    @(posedge i_ref_clk) disable iff (!rst_b)
    (mode == OTB_MODE_GATED) && gate_lvl |=> !o_clamp;
  endproperty
  a_gate_run: assert property (p_gate_run) else $error("gate high but clamped");

  property p_gate_stop;
    @(posedge i_ref_clk) disable iff (!rst_b)
    (mode == OTB_MODE_GATED) && !gate_lvl && !osc_rise ##1 (mode == OTB_MODE_GATED) && !gate_lvl
      |-> o_clamp == $past(run_hold_reg);
  endproperty
  a_gate_stop: assert property (p_gate_stop) else $error("gate stopped mid cycle");

  property p_burst_hold;
    @(posedge i_ref_clk) disable iff (!rst_b)
    (mode == OTB_MODE_BURST) && !burst_end_reg && !o_clamp && !trig_pulse |=> !o_clamp;
  endproperty
  a_burst_hold: assert property (p_burst_hold) else $error("burst stopped early");

  property p_burst_start;
    @(posedge i_ref_clk) disable iff (!rst_b)
    (mode == OTB_MODE_BURST) && trig_pulse |=> !o_clamp && !o_burst_end && cnt_val == $past(preload);
  endproperty
  a_burst_start: assert property (p_burst_start) else $error("burst start wrong");

  property p_burst_end;
    @(posedge i_ref_clk) disable iff (!rst_b)
    s_burst_last |=> o_burst_end && !o_clamp;
  endproperty
  a_burst_end: assert property (p_burst_end) else $error("burst end not set");

  property p_burst_stop;
    @(posedge i_ref_clk) disable iff (!rst_b)
    s_burst_stop |=> o_clamp && !o_sync;
  endproperty
  a_burst_stop: assert property (p_burst_stop) else $error("burst did not stop");

  property p_burst_idle;
    @(posedge i_ref_clk) disable iff (!rst_b)
    (mode == OTB_MODE_BURST) && o_clamp && !trig_pulse |=> o_clamp;
  endproperty
  a_burst_idle: assert property (p_burst_idle) else $error("idle burst released");

  property p_burst_sync;
    @(posedge i_ref_clk) disable iff (!rst_b)
    $past(mode == OTB_MODE_BURST) && (mode == OTB_MODE_BURST) |-> o_sync == !o_clamp;
  endproperty
  a_burst_sync: assert property (p_burst_sync) else $error("sync not burst length");

endmodule : otb_trigger_gate

// File: src/otb_cfg.svh
// Purpose: Named constants for the oscillator trigger, burst and gate block
// Assumes: Single 100 MHz reference clock
// Notes:   Included by both design modules of the block, not by the package
`ifndef OTB_CFG_SVH
`define OTB_CFG_SVH

// Burst counter geometry
`define OTB_CNT_W        12
`define OTB_CNT_MAX      12'hfff
`define OTB_CNT_ZERO     12'h000
`define OTB_CNT_ONE      12'h001
// Preload bias: one edge to leave terminal count, one edge to clamp
`define OTB_PRELOAD_BIAS 12'h002
// Shortest burst that the preload can express
`define OTB_BURST_MIN    12'h002

// Mode input width
`define OTB_MODE_W       2

// Run-hold levels
`define OTB_HOLD_CLAMP   1'b1
`define OTB_HOLD_RUN     1'b0

`endif

// File: src/otb_pkg.sv
// Purpose: Types for the oscillator trigger, burst and gate block
// Assumes: Modes are listed in selector order
// Notes:   Constants live in otb_cfg.svh
package otb_pkg;

  typedef enum logic [1:0] {
    OTB_MODE_CONT,
    OTB_MODE_TRIG,
    OTB_MODE_GATED,
    OTB_MODE_BURST
  } otb_mode_t;

endpackage : otb_pkg

// File: src/otb_burst_counter.sv
// Purpose: Twelve-bit burst counter with preload
// Assumes: Step is a one-cycle pulse per oscillator rising edge
// Notes:   Load wins over step
`timescale 1ns/10ps
`include "otb_cfg.svh"

module otb_burst_counter
  import otb_pkg::*;
(
  // Clock and reset
  input  wire logic                 i_ref_clk,
  input  wire logic                 i_rst_b,
  // Control
  input  wire logic                 i_load,
  input  wire logic [`OTB_CNT_W-1:0] i_load_val,
  input  wire logic                 i_step,
  // Status
  output logic      [`OTB_CNT_W-1:0] o_count,
  output logic                      o_at_max
);

  logic [`OTB_CNT_W-1:0] cnt_reg;
  logic [`OTB_CNT_W-1:0] cnt_next;

  always_comb begin
    cnt_next = cnt_reg;
    if (i_load) begin
      cnt_next = i_load_val;
    end else if (i_step) begin
      cnt_next = cnt_reg + `OTB_CNT_ONE;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cnt_reg <= `OTB_CNT_ZERO;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  assign o_count  = cnt_reg;
  assign o_at_max = (cnt_reg == `OTB_CNT_MAX);

endmodule : otb_burst_counter

// File: verif/otb_osc_model.sv
// Purpose: Behavioural waveform oscillator for the trigger gate bench
// Assumes: Clamp high halts the square output at its present level
// Notes:   Half period is counted in reference clock cycles
`timescale 1ns/10ps

module otb_osc_model #(
  parameter int HALF = 6
) (
  // Clock and control
  input  wire logic i_ref_clk,
  input  wire logic i_clamp,
  // Square output
  output logic      o_osc_square
);
  int phase_reg;

  initial begin
    o_osc_square = 1'b0;
    phase_reg    = 0;
  end

  // Free running unless clamped
  always @(posedge i_ref_clk) begin
    if (i_clamp) begin
      phase_reg <= 0;
    end else if (phase_reg == HALF - 1) begin
      phase_reg    <= 0;
      o_osc_square <= ~o_osc_square;
    end else begin
      phase_reg <= phase_reg + 1;
    end
  end
endmodule : otb_osc_model

// File: verif/test_otb_trigger_gate.sv
// Purpose: Self-checking bench for the trigger, gate and burst block
// Assumes: Oscillator half period of six reference cycles
// Notes:   Rising oscillator edges are counted between release and clamp
`timescale 1ns/10ps
`include "otb_cfg.svh"

module test_otb_trigger_gate
  import otb_pkg::*;
;
  logic        i_ref_clk      = 1'b0;
  logic        i_rst_b        = 1'b0;
  logic        i_trig_in      = 1'b0;
  logic [1:0]  i_trig_mode    = 2'h0;
  logic [11:0] i_burst_cycles = 12'h002;
  logic        i_osc_square;
  logic        o_clamp;
  logic        o_sync;
  logic        o_burst_end;
  logic        osc_prev       = 1'b0;
  logic        flag;
  logic [11:0] cyc;
  int          mismatches     = 0;
  int          samples_checked = 0;
  int          seed           = 32'habfc2bdf;
  int          rises          = 0;
  int          base;
  int          i;
  int          k;

  always #5 i_ref_clk = ~i_ref_clk;

  always @(posedge i_ref_clk) begin
    osc_prev <= i_osc_square;
    if (i_osc_square && !osc_prev) begin
      rises <= rises + 1;
    end
  end

  otb_trigger_gate dut (
    .i_ref_clk      (i_ref_clk),
    .i_rst_b        (i_rst_b),
    .i_trig_mode    (i_trig_mode),
    .i_burst_cycles (i_burst_cycles),
    .i_osc_square   (i_osc_square),
    .i_trig_in      (i_trig_in),
    .o_clamp        (o_clamp),
    .o_sync         (o_sync),
    .o_burst_end    (o_burst_end)
  );

  otb_osc_model osc (
    .i_ref_clk    (i_ref_clk),
    .i_clamp      (o_clamp),
    .o_osc_square (i_osc_square)
  );

  task automatic close_out;
    if (mismatches == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : close_out

  task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check_val

  // Bounded wait for a clamp level, watching sync while running
  task automatic wait_clamp(input logic lvl);
    for (k = 0; k < 8000 && o_clamp !== lvl; k++) begin
      @(posedge i_ref_clk);
      if (o_clamp === 1'b0 && o_sync !== 1'b1) flag = 1'b1;
    end
    if (o_clamp !== lvl) begin
      mismatches++;
      close_out();
    end
  endtask : wait_clamp

  // Trigger source pulse, high and low for four cycles each
  task automatic pulse_trig;
    i_trig_in <= 1'b1;
    repeat (4) @(posedge i_ref_clk);
    i_trig_in <= 1'b0;
    repeat (4) @(posedge i_ref_clk);
  endtask : pulse_trig

  function automatic int exp_burst(input logic [11:0] c);
    return (c < 12'h002) ? 2 : int'(c);
  endfunction : exp_burst

  initial begin
    repeat (5) @(posedge i_ref_clk);
    i_rst_b <= 1'b1;
    repeat (6) @(posedge i_ref_clk);
    i_trig_mode <= OTB_MODE_CONT;
    repeat (6) @(posedge i_ref_clk);
    base = rises;
    pulse_trig();
    flag = 1'b0;
    repeat (100) @(posedge i_ref_clk) flag |= o_clamp;
    check_val(16'(flag), 16'h0000);
    check_val(16'(rises - base >= 8), 16'h0001);
    i_trig_mode <= OTB_MODE_TRIG;
    wait_clamp(1'b1);
    for (i = 0; i < 3; i++) begin
      base = rises;
      pulse_trig();
      check_val(16'(o_clamp), 16'h0000);
      wait_clamp(1'b1);
      repeat (20) @(posedge i_ref_clk);
      check_val(16'(rises - base), 16'h0001);
    end
    i_trig_mode <= OTB_MODE_GATED;
    i_trig_in <= 1'b1;
    repeat (6) @(posedge i_ref_clk);
    base = rises;
    flag = 1'b0;
    repeat (30 + ($random(seed) & 63)) @(posedge i_ref_clk) flag |= o_clamp;
    check_val(16'(flag), 16'h0000);
    check_val(16'(rises - base >= 1), 16'h0001);
    for (k = 0; k < 40 && !(osc_prev && !i_osc_square); k++) @(posedge i_ref_clk);
    if (!(osc_prev && !i_osc_square)) begin
      mismatches++;
      close_out();
    end
    i_trig_in <= 1'b0;
    base = rises;
    wait_clamp(1'b1);
    repeat (20) @(posedge i_ref_clk);
    check_val(16'(rises - base), 16'h0001);
    i_trig_mode <= OTB_MODE_BURST;
    for (i = 0; i < 8; i++) begin
      case (i)
        0: cyc = 12'h000;
        1: cyc = 12'h001;
        2: cyc = 12'h002;
        3: cyc = 12'h12c;
        default: cyc = 12'h002 + 12'($random(seed) & 31);
      endcase
      i_burst_cycles <= cyc;
      repeat (4) @(posedge i_ref_clk);
      check_val(16'(o_clamp), 16'h0001);
      base = rises;
      flag = 1'b0;
      pulse_trig();
      check_val(16'(o_burst_end), 16'h0000);
      wait_clamp(1'b1);
      repeat (20) @(posedge i_ref_clk);
      check_val(16'(rises - base), 16'(exp_burst(cyc)));
      check_val(16'(o_burst_end), 16'h0001);
      check_val(16'(flag), 16'h0000);
      check_val(16'(o_sync), 16'h0000);
    end
    close_out();
  end
endmodule : test_otb_trigger_gate
